// >>> timer_counter_regs.vh
// Register map, field positions and timing constants of the timer/counter unit.
// Assumes a Wishbone slave with 32-bit data; each register sits in one aligned word.
`ifndef TIMER_COUNTER_REGS_VH
`define TIMER_COUNTER_REGS_VH
// Register indices as printed; byte address is four times the index.
`define IDX_MODE_CTRL   8'h89
`define IDX_T0_LOW      8'h8a
`define IDX_T1_LOW      8'h8b
`define IDX_T0_HIGH     8'h8c
`define IDX_T1_HIGH     8'h8d
`define IDX_AUX_TWO     8'ha3
`define IDX_AUX_THREE   8'ha4
`define IDX_AUX_FOUR    8'ha5
`define IDX_T_CTRL      8'hb0
`define IDX_T2_CTRL     8'hb1
`define IDX_T2_SEL      8'hb2
`define IDX_T2_LOW      8'hb3
`define IDX_T2_HIGH     8'hb4
`define IDX_T2_CAP_LOW  8'hb5
`define IDX_T2_CAP_HIGH 8'hb6
`define IDX_IRQ_ACK     8'hb7
`define REG_RESET       8'h00
// Mode control fields.
`define F_T1_GATE       7
`define F_T1_CSEL       6
`define F_T1_MODE       4
`define F_T0_GATE       3
`define F_T0_CSEL       2
`define F_T0_MODE       0
// Auxiliary two fields.
`define F_T1_FAST       3
`define F_T0_FAST       2
`define F_T1_CKOE       1
`define F_T0_CKOE       0
// Auxiliary three and four fields.
`define F_T0_ROUTE      6
`define F_T0_XL         0
`define F_T1_ROUTE      4
// Timer control fields.
`define F_T1_OVF        3
`define F_T1_RUN        2
`define F_T0_OVF        1
`define F_T0_RUN        0
// Timer 2 control fields.
`define F_T2_OVF        7
`define F_T2_EXT        6
`define F_T2_IGN        5
`define F_T2_FALL       4
`define F_T2_RISE       3
`define F_T2_RUN        2
`define F_T2_MODE       0
// Timer 2 select fields.
`define F_T2_CSRC       0
`define F_T2_TSRC       4
// Prescale divisors.
`define DIV_12          8'd12
`define DIV_48          8'd48
`define DIV_192         8'd192
`endif

// >>> timer_counter_unit.v
// Timer 0, timer 1 and timer 2 with their control registers on a Wishbone slave.
// Assumes one 20 MHz clock, synchronous active-high reset, and pins from outside.
// Function
// - Timer 1 gated by irq1 level when enabled.
// - Timer 0 gated by irq0 level when enabled.
// - Timer 1 modes: PWM, 16-bit, reload, stopped.
// - Timer 0 mode three splits into two bytes.
// - Timer 1 clock source from two bits.
// - Timer 0 clock source from three bits.
// - Timer 1 clock output when enabled.
// - Timer 0 clock output when enabled.
// - Timer 0 pin routed among four pins.
// - Timer 1 pin routed; code 10 reserved.
// - Timer 2 overflow interrupt can be ignored.
// - Timer 2 eight clocks, eight triggers.
// - Mode 0 falling trigger sets external flag.
// - Rising enable mirrors falling enable.
// - Timer 2 overflow exported as pulse.
// - Mode 1 overflow reloads from capture bytes.
// - Mode 1 trigger also reloads, sets flag.
// - Timer 2 request from either flag.
// - Mode 2 trigger captures count bytes.
// - Count pin high-then-low increments counter.
// - Run bits start; overflow flags set, cleared.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
`include "timer_counter_regs.vh"
module timer_counter_unit
(
  input  wire        clk,              // System clock, 20 MHz.
  input  wire        sys_rst,          // Synchronous reset, active high.
  input  wire        wb_cyc_i,         // Wishbone cycle.
  input  wire        wb_stb_i,         // Wishbone strobe.
  input  wire        wb_we_i,          // Wishbone write enable.
  input  wire [31:0] wb_adr_i,         // Wishbone byte address.
  input  wire [3:0]  wb_sel_i,         // Wishbone byte selects.
  input  wire [31:0] wb_dat_i,         // Wishbone write data.
  output reg  [31:0] wb_dat_o,         // Wishbone read data.
  output reg         wb_ack_o,         // Wishbone acknowledge.
  output reg         wb_err_o,         // Wishbone error on unmapped address.
  input  wire [3:0]  tmr0PinIn,        // Timer 0 pins P3.4, P4.4, P2.2, P2.6.
  input  wire [3:0]  tmr1PinIn,        // Timer 1 pins P3.5, P4.5, unused, P2.6.
  input  wire        extIrq0Level,     // External interrupt 0 level.
  input  wire        extIrq1Level,     // External interrupt 1 level.
  input  wire        lowSpeedRcOsc,    // Low-speed RC oscillator.
  input  wire        watchdogPsOut,    // Watchdog prescaler output.
  input  wire [7:0]  tmr2ClockSrc,     // Timer 2 clock sources 1 to 7 (bit 0 unused).
  input  wire [7:0]  tmr2TriggerSrc,   // Timer 2 trigger sources.
  input  wire        tmr0IrqVectored,  // Pulse: timer 0 interrupt vectored.
  input  wire        tmr1IrqVectored,  // Pulse: timer 1 interrupt vectored.
  output reg  [3:0]  tmr0PinOut,       // Timer 0 clock out per pin.
  output reg  [3:0]  tmr0PinOe,        // Timer 0 output enables per pin.
  output reg  [3:0]  tmr1PinOut,       // Timer 1 clock out per pin.
  output reg  [3:0]  tmr1PinOe,        // Timer 1 output enables per pin.
  output reg         tmr0Pwm,          // Timer 0 mode-0 PWM output.
  output reg         tmr1Pwm,          // Timer 1 mode-0 PWM output.
  output wire        tmr0Irq,          // Timer 0 flag level.
  output wire        tmr1Irq,          // Timer 1 flag level.
  output wire        tmr2Irq,          // Timer 2 request level.
  output reg         tmr2OverflowPulse // One-cycle timer 2 overflow event.
);
  reg  [7:0] modeCtrl, aux2, aux3, aux4, tCtrl, t2Ctrl, t2Sel;
  reg  [7:0] t0Lo, t0Hi, t1Lo, t1Hi, t2Lo, t2Hi, t2CapLo, t2CapHi;
  reg  [7:0] pre12, pre48, pre192;
  reg        t0ClkOut, t1ClkOut, t1OvfPulse;
  reg  [2:0] s0Sync, s1Sync, rcSync, t2cSync, t2tSync, g0Sync, g1Sync;
  reg        s0Last, s1Last, rcLast, t2cLast, t2tLast;
  wire       sel     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire [7:0] regIdx  = wb_adr_i[9:2];
  // Writes land at the edge that shows ack to the master, not at the edge that takes the request.
  wire       wr      = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire [7:0] wd      = wb_dat_i[7:0];

  // A filtered level counts only once the two late stages agree.
  function edgeFall;
    input [2:0] sy;
    input       last;
    begin
      edgeFall = (sy[2] == sy[1]) && last && !sy[2];
    end
  endfunction
  function stable;
    input [2:0] sy;
    input       last;
    begin
      stable = (sy[2] == sy[1]) ? sy[2] : last;
    end
  endfunction

  // Prescaler ticks: tick12 shared by all three timers, tick48 by timers 0 and 1, tick192 by timer 0 alone.
  wire tick12  = (pre12 == `DIV_12 - 8'd1);
  wire tick48  = (pre48 == `DIV_48 - 8'd1);
  wire tick192 = (pre192 == `DIV_192 - 8'd1);

  // Pins are routed before synchronising; keeps them slow enough to sample.
  wire pin0 = tmr0PinIn[aux3[`F_T0_ROUTE+:2]];
  wire pin1 = (aux4[`F_T1_ROUTE+:2] == 2'b10) ? 1'b0 :
              tmr1PinIn[aux4[`F_T1_ROUTE+:2]];
  wire pinTick0 = edgeFall(s0Sync, s0Last);
  wire pinTick1 = edgeFall(s1Sync, s1Last);
  wire rcTick   = edgeFall(rcSync, rcLast);

  reg  src0, src1;
  always @*
  begin
    case ({aux3[`F_T0_XL], aux2[`F_T0_FAST], modeCtrl[`F_T0_CSEL]})
      3'b000:  src0 = tick12;
      3'b001:  src0 = pinTick0;
      3'b010:  src0 = 1'b1;
      3'b011:  src0 = rcTick;
      3'b100:  src0 = tick48;
      3'b101:  src0 = watchdogPsOut;
      3'b110:  src0 = tick192;
      default: src0 = t1OvfPulse;
    endcase
    case ({aux2[`F_T1_FAST], modeCtrl[`F_T1_CSEL]})
      2'b00:   src1 = tick12;
      2'b01:   src1 = pinTick1;
      2'b10:   src1 = 1'b1;
      default: src1 = tick48;
    endcase
  end

  wire g0 = stable(g0Sync, g0Sync[2]);
  wire g1 = stable(g1Sync, g1Sync[2]);
  wire [1:0] m0 = modeCtrl[`F_T0_MODE+:2];
  wire [1:0] m1 = modeCtrl[`F_T1_MODE+:2];
  wire run0 = tCtrl[`F_T0_RUN] && (!modeCtrl[`F_T0_GATE] || g0);
  wire run1 = tCtrl[`F_T1_RUN] && (!modeCtrl[`F_T1_GATE] || g1);
  wire inc0 = run0 && src0;
  // In timer 0 mode 3 the high byte borrows timer 1's run bit and counts system_clock/12.
  wire incHi0 = (m0 == 2'b11) && tCtrl[`F_T1_RUN] && tick12;
  wire inc1 = run1 && src1 && (m1 != 2'b11);
  wire ck0 = aux2[`F_T0_CKOE];
  wire ck1 = aux2[`F_T1_CKOE];
  // Clock-out forces eight-bit auto-reload operation.
  wire reload0 = ck0 || (m0 == 2'b10) || (m0 == 2'b00);
  wire reload1 = ck1 || (m1 == 2'b10) || (m1 == 2'b00);
  wire ovf0Lo = inc0 && (t0Lo == 8'hff);
  wire ovf0 = reload0 || (m0 == 2'b11) ? ovf0Lo : ovf0Lo && (t0Hi == 8'hff);
  wire ovf1Lo = inc1 && (t1Lo == 8'hff);
  wire ovf1 = reload1 ? ovf1Lo : ovf1Lo && (t1Hi == 8'hff);
  wire ovfHi0 = incHi0 && (t0Hi == 8'hff);

  // Timer 2 clock and trigger selection.
  wire [2:0] t2cs = t2Sel[`F_T2_CSRC+:3];
  wire t2cTick = edgeFall(t2cSync, t2cLast);
  wire t2Src = (t2cs == 3'd0) ? tick12 : t2cTick;
  wire t2tLvl = stable(t2tSync, t2tLast);
  wire trigFall = t2Ctrl[`F_T2_FALL] && (t2tSync[2] == t2tSync[1]) && t2tLast && !t2tLvl;
  wire trigRise = t2Ctrl[`F_T2_RISE] && (t2tSync[2] == t2tSync[1]) && !t2tLast && t2tLvl;
  wire trig = trigFall || trigRise;
  wire [1:0] m2 = t2Ctrl[`F_T2_MODE+:2];
  wire inc2 = t2Ctrl[`F_T2_RUN] && t2Src;
  wire ovf2 = inc2 && ({t2Hi, t2Lo} == 16'hffff);
  wire [15:0] t2Next = {t2Hi, t2Lo} + 16'h0001;

  assign tmr0Irq = tCtrl[`F_T0_OVF];
  assign tmr1Irq = tCtrl[`F_T1_OVF];
  assign tmr2Irq = (t2Ctrl[`F_T2_OVF] && !t2Ctrl[`F_T2_IGN]) || t2Ctrl[`F_T2_EXT];

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      {s0Sync, s1Sync, rcSync, t2cSync, t2tSync, g0Sync, g1Sync} <= 21'h000000;
      {s0Last, s1Last, rcLast, t2cLast, t2tLast} <= 5'h00;
    end
    else
    begin
      s0Sync  <= {s0Sync[1:0], pin0};
      s1Sync  <= {s1Sync[1:0], pin1};
      rcSync  <= {rcSync[1:0], lowSpeedRcOsc};
      t2cSync <= {t2cSync[1:0], tmr2ClockSrc[t2cs]};
      t2tSync <= {t2tSync[1:0], tmr2TriggerSrc[t2Sel[`F_T2_TSRC+:3]]};
      g0Sync  <= {g0Sync[1:0], extIrq0Level};
      g1Sync  <= {g1Sync[1:0], extIrq1Level};
      s0Last  <= stable(s0Sync, s0Last);
      s1Last  <= stable(s1Sync, s1Last);
      rcLast  <= stable(rcSync, rcLast);
      t2cLast <= stable(t2cSync, t2cLast);
      t2tLast <= t2tLvl;
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pre12  <= 8'h00;
      pre48  <= 8'h00;
      pre192 <= 8'h00;
    end
    else
    begin
      pre12  <= tick12  ? 8'h00 : pre12 + 8'h01;
      pre48  <= tick48  ? 8'h00 : pre48 + 8'h01;
      pre192 <= tick192 ? 8'h00 : pre192 + 8'h01;
    end
  end

  // Control registers and counters; hardware events win over software clears.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      modeCtrl <= `REG_RESET;
      aux2 <= `REG_RESET;
      aux3 <= `REG_RESET;
      aux4 <= `REG_RESET;
      tCtrl <= `REG_RESET;
      t2Ctrl <= `REG_RESET;
      t2Sel <= `REG_RESET;
      t0Lo <= `REG_RESET;
      t0Hi <= `REG_RESET;
      t1Lo <= `REG_RESET;
      t1Hi <= `REG_RESET;
      t2Lo <= `REG_RESET;
      t2Hi <= `REG_RESET;
      t2CapLo <= `REG_RESET;
      t2CapHi <= `REG_RESET;
      t0ClkOut <= 1'b0;
      t1ClkOut <= 1'b0;
      t1OvfPulse <= 1'b0;
      tmr2OverflowPulse <= 1'b0;
    end
    else
    begin
      if (wr && regIdx == `IDX_MODE_CTRL) modeCtrl <= wd;
      if (wr && regIdx == `IDX_AUX_TWO) aux2 <= {4'h0, wd[3:0]};
      if (wr && regIdx == `IDX_AUX_THREE) aux3 <= wd;
      if (wr && regIdx == `IDX_AUX_FOUR) aux4 <= wd;
      if (wr && regIdx == `IDX_T2_SEL) t2Sel <= {1'b0, wd[6:4], 1'b0, wd[2:0]};
      // Timer 0 counting.
      if (wr && regIdx == `IDX_T0_LOW) t0Lo <= wd;
      else if (inc0)
        t0Lo <= (ovf0Lo && reload0) ? t0Hi : t0Lo + 8'h01;
      if (wr && regIdx == `IDX_T0_HIGH) t0Hi <= wd;
      else if (m0 == 2'b11) begin if (incHi0) t0Hi <= t0Hi + 8'h01; end
      else if (ovf0Lo && !reload0) t0Hi <= t0Hi + 8'h01;
      // Timer 1 counting.
      if (wr && regIdx == `IDX_T1_LOW) t1Lo <= wd;
      else if (inc1)
        t1Lo <= (ovf1Lo && reload1) ? t1Hi : t1Lo + 8'h01;
      if (wr && regIdx == `IDX_T1_HIGH) t1Hi <= wd;
      else if (ovf1Lo && !reload1) t1Hi <= t1Hi + 8'h01;
      t1OvfPulse <= ovf1;
      if (ovf0) t0ClkOut <= !t0ClkOut;
      if (ovf1) t1ClkOut <= !t1ClkOut;
      // Timer control: run bits and overflow flags.
      begin : tctrlUpd
        reg [7:0] nt;
        nt = tCtrl;
        if (wr && regIdx == `IDX_T_CTRL) nt = {4'h0, wd[3:0]};
        if (tmr0IrqVectored) nt[`F_T0_OVF] = 1'b0;
        if (tmr1IrqVectored) nt[`F_T1_OVF] = 1'b0;
        if (ovf0) nt[`F_T0_OVF] = 1'b1;
        // Timer 0 mode 3 high byte takes over timer 1's flag.
        if ((m0 == 2'b11) ? ovfHi0 : ovf1) nt[`F_T1_OVF] = 1'b1;
        tCtrl <= nt;
      end
      // Timer 2 counting.
      tmr2OverflowPulse <= ovf2;
      if (wr && regIdx == `IDX_T2_LOW) t2Lo <= wd;
      else if (wr && regIdx == `IDX_T2_HIGH) t2Hi <= wd;
      else if ((m2 == 2'b01 && trig) || (ovf2 && m2 != 2'b10))
        {t2Hi, t2Lo} <= {t2CapHi, t2CapLo};
      else if (inc2)
        {t2Hi, t2Lo} <= t2Next;
      if (m2 == 2'b10 && trig)
        {t2CapHi, t2CapLo} <= {t2Hi, t2Lo};
      else if (wr && regIdx == `IDX_T2_CAP_LOW) t2CapLo <= wd;
      else if (wr && regIdx == `IDX_T2_CAP_HIGH) t2CapHi <= wd;
      begin : t2Upd
        reg [7:0] n2;
        n2 = t2Ctrl;
        if (wr && regIdx == `IDX_T2_CTRL) n2 = wd;
        if (wr && regIdx == `IDX_IRQ_ACK) n2[7:6] = n2[7:6] & ~wd[7:6];
        if (ovf2) n2[`F_T2_OVF] = 1'b1;
        if (trig) n2[`F_T2_EXT] = 1'b1;
        t2Ctrl <= n2;
      end
    end
  end

  // Clock outputs on the routed pins, and the mode-0 PWM outputs on their own ports.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      tmr0PinOut <= 4'h0;
      tmr0PinOe <= 4'h0;
      tmr1PinOut <= 4'h0;
      tmr1PinOe <= 4'h0;
      tmr0Pwm <= 1'b0;
      tmr1Pwm <= 1'b0;
    end
    else
    begin
      tmr0PinOut <= {4{t0ClkOut}};
      tmr0PinOe  <= ck0 ? (4'h1 << aux3[`F_T0_ROUTE+:2]) : 4'h0;
      tmr1PinOut <= {4{t1ClkOut}};
      tmr1PinOe  <= (ck1 && aux4[`F_T1_ROUTE+:2] != 2'b10) ?
                    (4'h1 << aux4[`F_T1_ROUTE+:2]) : 4'h0;
      tmr0Pwm <= (m0 == 2'b00) && (t0Lo >= t0Hi);
      tmr1Pwm <= (m1 == 2'b00) && (t1Lo >= t1Hi);
    end
  end

  // Bus answer: one cycle after the request, error for unmapped words.
  reg [7:0] rdata;
  reg       hit;
  always @*
  begin
    hit = 1'b1;
    case (regIdx)
      `IDX_MODE_CTRL:   rdata = modeCtrl;
      `IDX_T0_LOW:      rdata = t0Lo;
      `IDX_T1_LOW:      rdata = t1Lo;
      `IDX_T0_HIGH:     rdata = t0Hi;
      `IDX_T1_HIGH:     rdata = t1Hi;
      `IDX_AUX_TWO:     rdata = aux2;
      `IDX_AUX_THREE:   rdata = aux3;
      `IDX_AUX_FOUR:    rdata = aux4;
      `IDX_T_CTRL:      rdata = tCtrl;
      `IDX_T2_CTRL:     rdata = t2Ctrl;
      `IDX_T2_SEL:      rdata = t2Sel;
      `IDX_T2_LOW:      rdata = t2Lo;
      `IDX_T2_HIGH:     rdata = t2Hi;
      `IDX_T2_CAP_LOW:  rdata = t2CapLo;
      `IDX_T2_CAP_HIGH: rdata = t2CapHi;
      `IDX_IRQ_ACK:     rdata = 8'h00;
      default:
      begin
        rdata = 8'h00;
        hit = 1'b0;
      end
    endcase
    if (wb_adr_i[31:10] != 22'h000000 || wb_adr_i[1:0] != 2'b00) hit = 1'b0;
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= sel && hit;
      wb_err_o <= sel && !hit;
      wb_dat_o <= (sel && hit && !wb_we_i) ? {24'h000000, rdata} : 32'h00000000;
    end
  end
endmodule

// >>> timer_counter_unit_checker.sv
// Checker of the timer/counter unit bus answers and pin outputs.
// Assumes binding to timer_counter_unit, one clock and a synchronous reset.
`timescale 1ns/100ps
module timer_counter_unit_checker
(
  input wire        clk,              // Clock.
  input wire        sys_rst,          // Reset.
  input wire        wb_cyc_i,         // Cycle.
  input wire        wb_stb_i,         // Strobe.
  input wire [31:0] wb_adr_i,         // Address.
  input wire [31:0] wb_dat_o,         // Read data.
  input wire        wb_ack_o,         // Acknowledge.
  input wire        wb_err_o,         // Error.
  input wire [3:0]  tmr0PinOut,       // Timer 0 clock out.
  input wire [3:0]  tmr0PinOe,        // Timer 0 enables.
  input wire [3:0]  tmr1PinOe,        // Timer 1 enables.
  input wire        tmr2OverflowPulse // Timer 2 event.
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence sAnswer;
    wb_ack_o || wb_err_o;
  endsequence
  a_bus_answer: assert property (sReq |=> sAnswer)
    else $error("bus request not answered in one cycle");
  a_answer_pulse: assert property (sAnswer |=> !wb_ack_o && !wb_err_o)
    else $error("bus answer longer than one cycle");
  a_unmapped_err: assert property (sReq and wb_adr_i[9:2] == 8'h00 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside acknowledge");
  a_t0_route: assert property ($onehot0(tmr0PinOe))
    else $error("timer 0 drives more than one pin");
  a_t1_route: assert property ($onehot0(tmr1PinOe) && !tmr1PinOe[2])
    else $error("timer 1 pin route wrong");
  a_t0_out_whole: assert property (tmr0PinOut == 4'h0 || tmr0PinOut == 4'hf)
    else $error("timer 0 clock out split");
  a_t2_event_pulse: assert property (tmr2OverflowPulse |=> !tmr2OverflowPulse)
    else $error("timer 2 event longer than one cycle");
endmodule
bind timer_counter_unit timer_counter_unit_checker chk_u
(
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .tmr0PinOut(tmr0PinOut), .tmr0PinOe(tmr0PinOe), .tmr1PinOe(tmr1PinOe),
  .tmr2OverflowPulse(tmr2OverflowPulse)
);

// >>> timer_pin_model.sv
// Model of the outside pins: count pins, timer 2 clock and trigger sources.
// Assumes the bench calls pulse; lines idle high like pulled-up port pins.
`timescale 1ns/100ps
module timer_pin_model
(
  input  wire       clk,      // System clock.
  output reg  [3:0] t0Pins,   // Timer 0 count pins.
  output reg  [3:0] t1Pins,   // Timer 1 count pins.
  output reg  [7:0] t2Clocks, // Timer 2 clock sources.
  output reg  [7:0] t2Trigs   // Timer 2 trigger sources.
);
  initial
  begin
    t0Pins = 4'hf;
    t1Pins = 4'hf;
    t2Clocks = 8'hff;
    t2Trigs = 8'hff;
  end
  // Each level stays seven clocks, well below half the system clock rate.
  task automatic pulse(input int grp, input int idx);
    int k;
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk);
      case (grp)
        0: t0Pins[idx] <= k[0];
        1: t1Pins[idx] <= k[0];
        2: t2Clocks[idx] <= k[0];
        default: t2Trigs[idx] <= k[0];
      endcase
      repeat (6) @(posedge clk);
    end
  endtask
endmodule

// >>> tb_timer_counter_unit.sv
// Self-checking bench of the timer/counter unit over its Wishbone registers.
// Assumes the pin model and the checker bound beside the unit.
`timescale 1ns/100ps
`include "timer_counter_regs.vh"
module tb_timer_counter_unit;
  localparam [63:0] REGS = {`IDX_MODE_CTRL, `IDX_T0_LOW, `IDX_T1_LOW, `IDX_T0_HIGH,
                            `IDX_T1_HIGH, `IDX_AUX_TWO, `IDX_AUX_THREE, `IDX_AUX_FOUR};
  reg         clk;
  reg         sysRst;
  reg         req;
  reg         we;
  reg  [31:0] adr;
  reg  [31:0] wdat;
  reg         irq0Level;
  reg         irq1Level;
  reg         t0Vectored;
  reg  [31:0] q;
  reg         e;
  reg  [7:0]  lo;
  reg  [1:0]  outPrev;
  wire [31:0] rdat;
  wire        ack;
  wire        err;
  wire [3:0]  t0Pins, t1Pins, t0Out, t0Oe, t1Out, t1Oe;
  wire [7:0]  t2Clocks, t2Trigs;
  wire        t0Irq, t1Irq, t2Irq, t2Pulse;
  integer     miscompares, checked, t2Pulses, outEdges;
  int         t, r, k;
  timer_counter_unit dut_u
  (
    .clk(clk), .sys_rst(sysRst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .tmr0PinIn(t0Pins), .tmr1PinIn(t1Pins), .extIrq0Level(irq0Level),
    .extIrq1Level(irq1Level), .lowSpeedRcOsc(1'b0), .watchdogPsOut(1'b0),
    .tmr2ClockSrc(t2Clocks), .tmr2TriggerSrc(t2Trigs), .tmr0IrqVectored(t0Vectored),
    .tmr1IrqVectored(1'b0), .tmr0PinOut(t0Out), .tmr0PinOe(t0Oe), .tmr1PinOut(t1Out),
    .tmr1PinOe(t1Oe), .tmr0Pwm(), .tmr1Pwm(), .tmr0Irq(t0Irq), .tmr1Irq(t1Irq),
    .tmr2Irq(t2Irq), .tmr2OverflowPulse(t2Pulse)
  );
  timer_pin_model pins_u
  (
    .clk(clk), .t0Pins(t0Pins), .t1Pins(t1Pins), .t2Clocks(t2Clocks), .t2Trigs(t2Trigs)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    outPrev <= {t0Out[0], t1Out[0]};
    if (outPrev !== {t0Out[0], t1Out[0]})
      outEdges <= outEdges + 1;
    if (t2Pulse === 1'b1)
      t2Pulses <= t2Pulses + 1;
  end
  task report_and_stop;
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits for the answer under a bound; a silent slave ends the run.
  task xfer(input bit w, input [7:0] idx, input [7:0] d);
    int n;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= {22'h0, idx, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat;
    e = err;
    req <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1)
    begin
      chk("bus answer", 0, 1);
      report_and_stop();
    end
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task rd(input [7:0] idx);
    xfer(1'b0, idx, 8'h00);
  endtask
  initial
  begin
    sysRst = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    wdat = 32'h0;
    irq0Level = 1'b0;
    irq1Level = 1'b0;
    t0Vectored = 1'b0;
    outPrev = 2'b00;
    miscompares = 0;
    checked = 0;
    t2Pulses = 0;
    outEdges = 0;
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    for (k = 0; k < 8; k++)
    begin
      rd(REGS[56 - 8 * k +: 8]);
      chk("reset value", q, 0);
    end
    rd(8'h00);
    chk("unmapped error", e, 1);
    for (k = 1; k < 5; k++)
    begin
      wr(REGS[56 - 8 * k +: 8], 8'(8'h5a + k));
      rd(REGS[56 - 8 * k +: 8]);
      chk("count write", q, 8'h5a + k);
    end
    $display("test registers done");
    for (t = 0; t < 2; t++)
    begin
      lo = t ? `IDX_T1_LOW : `IDX_T0_LOW;
      wr(`IDX_T_CTRL, 8'h00);
      wr(`IDX_AUX_TWO, t ? 8'h08 : 8'h04);
      wr(`IDX_MODE_CTRL, t ? 8'h90 : 8'h09);
      wr(lo, 8'h00);
      wr(`IDX_T_CTRL, t ? 8'h04 : 8'h01);
      repeat (20) @(posedge clk);
      rd(lo);
      chk("gate closed", q, 0);
      if (t)
        irq1Level <= 1'b1;
      else
        irq0Level <= 1'b1;
      repeat (20) @(posedge clk);
      rd(lo);
      chk("gate open", q != 0, 1);
    end
    $display("test gating done");
    wr(`IDX_AUX_TWO, 8'h00);
    wr(`IDX_MODE_CTRL, 8'h55);
    for (t = 0; t < 2; t++)
      for (r = 0; r < 4; r++)
        if (!(t == 1 && r == 2))
        begin
          lo = t ? `IDX_T1_LOW : `IDX_T0_LOW;
          wr(t ? `IDX_AUX_FOUR : `IDX_AUX_THREE, 8'(r << (t ? 4 : 6)));
          wr(lo, 8'h00);
          wr(`IDX_T_CTRL, t ? 8'h04 : 8'h01);
          for (k = 0; k < 3; k++)
            pins_u.pulse(t, r);
          pins_u.pulse(t, (r + 1) % 4);
          repeat (4) @(posedge clk);
          rd(lo);
          chk("pin count", q, 3);
        end
    $display("test counting pins done");
    wr(`IDX_T_CTRL, 8'h00);
    wr(`IDX_AUX_TWO, 8'h04);
    wr(`IDX_MODE_CTRL, 8'h01);
    wr(`IDX_T0_HIGH, 8'hff);
    wr(`IDX_T0_LOW, 8'hf0);
    wr(`IDX_T_CTRL, 8'h01);
    k = 0;
    do
    begin
      rd(`IDX_T_CTRL);
      k++;
    end
    while (q[1] !== 1'b1 && k < 100);
    chk("overflow flag", q[1], 1);
    chk("overflow irq", t0Irq, 1);
    t0Vectored <= 1'b1;
    @(posedge clk);
    t0Vectored <= 1'b0;
    repeat (2) @(posedge clk);
    chk("vector clears", t0Irq, 0);
    wr(`IDX_MODE_CTRL, 8'h22);
    for (t = 0; t < 2; t++)
    begin
      wr(`IDX_T_CTRL, 8'h00);
      wr(t ? `IDX_AUX_FOUR : `IDX_AUX_THREE, t ? 8'h30 : 8'h80);
      wr(t ? `IDX_T1_HIGH : `IDX_T0_HIGH, 8'hfc);
      wr(t ? `IDX_T1_LOW : `IDX_T0_LOW, 8'hfc);
      wr(`IDX_AUX_TWO, t ? 8'h0a : 8'h05);
      k = outEdges;
      wr(`IDX_T_CTRL, t ? 8'h04 : 8'h01);
      repeat (40) @(posedge clk);
      chk("clock out enable", t ? t1Oe : t0Oe, t ? 4'h8 : 4'h4);
      chk("clock out toggles", outEdges - k > 4, 1);
      wr(`IDX_AUX_TWO, t ? 8'h08 : 8'h04);
      repeat (2) @(posedge clk);
      chk("clock out off", t ? t1Oe : t0Oe, 0);
    end
    $display("test timer 0 and 1 outputs done");
    for (k = 0; k < 8; k++)
    begin
      wr(`IDX_T2_SEL, 8'(k << 4));
      wr(`IDX_T2_LOW, 8'(k));
      wr(`IDX_T2_HIGH, 8'(8'h40 + k));
      wr(`IDX_T2_CTRL, k[0] ? 8'h0a : 8'h12);
      pins_u.pulse(3, k);
      rd(`IDX_T2_CAP_LOW);
      chk("capture low", q, k);
      rd(`IDX_T2_CAP_HIGH);
      chk("capture high", q, 8'h40 + k);
      chk("external irq", t2Irq, 1);
      wr(`IDX_IRQ_ACK, 8'h40);
      @(posedge clk);
      chk("external irq cleared", t2Irq, 0);
    end
    wr(`IDX_T2_SEL, 8'h00);
    wr(`IDX_T2_CAP_LOW, 8'hcd);
    wr(`IDX_T2_CAP_HIGH, 8'hab);
    for (k = 0; k < 2; k++)
    begin
      wr(`IDX_T2_LOW, 8'h11);
      wr(`IDX_T2_CTRL, 8'(8'h10 + k));
      pins_u.pulse(3, 0);
      rd(`IDX_T2_LOW);
      chk("trigger reload", q, k ? 8'hcd : 8'h11);
      rd(`IDX_T2_CTRL);
      chk("external flag", q[6], 1);
      wr(`IDX_IRQ_ACK, 8'h40);
    end
    $display("test timer 2 triggers done");
    wr(`IDX_T2_SEL, 8'h01);
    wr(`IDX_T2_CAP_LOW, 8'h34);
    wr(`IDX_T2_CAP_HIGH, 8'h12);
    wr(`IDX_T2_LOW, 8'hfe);
    wr(`IDX_T2_HIGH, 8'hff);
    wr(`IDX_T2_CTRL, 8'h05);
    k = t2Pulses;
    pins_u.pulse(2, 1);
    pins_u.pulse(2, 1);
    repeat (4) @(posedge clk);
    chk("overflow event", t2Pulses - k, 1);
    rd(`IDX_T2_LOW);
    chk("reload low", q, 8'h34);
    rd(`IDX_T2_HIGH);
    chk("reload high", q, 8'h12);
    chk("overflow irq", t2Irq, 1);
    wr(`IDX_T2_CTRL, 8'ha5);
    @(posedge clk);
    chk("overflow ignored", t2Irq, 0);
    $display("test timer 2 overflow done");
    report_and_stop();
  end
endmodule
